// ==== rtl/pnce_consts.svh ====
// Constants for the parallel NOR flash host controller.
// Assumes inclusion by the package and the controller modules.
`ifndef PNCE_CONSTS_SVH
`define PNCE_CONSTS_SVH
`define PNCE_ADDR_UNLOCK1 22'h000555
`define PNCE_ADDR_UNLOCK2 22'h0002aa
`define PNCE_DATA_UNLOCK1 16'h00aa
`define PNCE_DATA_UNLOCK2 16'h0055
`define PNCE_CMD_PROGRAM 16'h00a0
`define PNCE_CMD_ERASE_SETUP 16'h0080
`define PNCE_CMD_CHIP_ERASE 16'h0010
`define PNCE_CMD_SECTOR_ERASE 16'h0050
`define PNCE_CMD_BLOCK_ERASE 16'h0030
`define PNCE_CMD_SUSPEND 16'h00b0
`define PNCE_CMD_RESUME 16'h0030
`define PNCE_CMD_CFI_ENTRY 16'h0098
`define PNCE_CMD_SECID_ENTRY 16'h0088
`define PNCE_CMD_ID_ENTRY 16'h0090
`define PNCE_CMD_EXIT 16'h00f0
`define PNCE_CMD_SECID_PROGRAM 16'h00a5
`define PNCE_CMD_SECID_LOCK 16'h0085
`define PNCE_BIT_POLL 7
`define PNCE_BIT_TOGGLE 6
`define PNCE_BIT_SECTOR_TOGGLE 2
`define PNCE_STROBE_NS 100
`define PNCE_CLK_NS 100
`define PNCE_RESET_PULSE_NS 500
`define PNCE_RECOVERY_NS 50000
`define PNCE_SUSPEND_NS 20000
`define PNCE_VALID_NS 1000
`define PNCE_POLL_LIMIT 32'h00100000
`endif

// ==== rtl/pnce_pkg.sv ====
// Types shared by the parallel NOR flash host controller.
// Assumes pnce_consts.svh sits beside it.
`include "pnce_consts.svh"
package pnce_pkg;
  // Operations the user may request.
  typedef enum logic [3:0] {
    PNCE_OP_READ, PNCE_OP_PROGRAM, PNCE_OP_SECTOR_ERASE, PNCE_OP_BLOCK_ERASE,
    PNCE_OP_CHIP_ERASE, PNCE_OP_SUSPEND, PNCE_OP_RESUME, PNCE_OP_CFI_ENTRY,
    PNCE_OP_ID_ENTRY, PNCE_OP_SECID_ENTRY, PNCE_OP_EXIT, PNCE_OP_SECID_PROGRAM,
    PNCE_OP_SECID_LOCK, PNCE_OP_HARD_RESET
  } pnce_op_t;
  // One bus write of a command sequence.
  typedef struct packed {
    logic [21:0] addr;
    logic [15:0] data;
  } pnce_word_t;
  // One user request.
  typedef struct packed {
    pnce_op_t op;
    logic [21:0] addr;
    logic [15:0] data;
  } pnce_req_t;
endpackage

// ==== rtl/pnce_cycle.sv ====
// One flash bus cycle, write or read, with timed strobes.
// Assumes a 10 MHz clock and the device on the same pins as the parent drives.
`timescale 1ns/1ps
`default_nettype none
`include "pnce_consts.svh"
module pnce_cycle
  import pnce_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Cycle request.
  input wire logic start,
  input wire logic is_write,
  input wire pnce_word_t word,
  output logic done,
  output logic [15:0] rd_data,
  // Flash pins as flip-flops.
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [21:0] addr,
  output logic [15:0] dq_out,
  output logic dq_oe,
  input wire logic [15:0] dq_sync
);
  // Strobe low time in cycles; rounded up, well above the glitch filter.
  localparam int unsigned LOW_CYC = (`PNCE_STROBE_NS + `PNCE_CLK_NS - 1) / `PNCE_CLK_NS;
  localparam int unsigned RD_CYC = LOW_CYC + 2;
  logic [3:0] cnt;
  logic busy;
  logic wr;

  // Address is set before the strobe falls and held past its rise, so the device sees it stable.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      wr <= 1'b0;
      cnt <= 4'h0;
      done <= 1'b0;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      addr <= 22'h000000;
      dq_out <= 16'h0000;
      dq_oe <= 1'b0;
      rd_data <= 16'h0000;
    end else begin
      done <= 1'b0;
      if (!busy && start) begin
        busy <= 1'b1;
        wr <= is_write;
        cnt <= 4'h0;
        addr <= word.addr;
        dq_out <= word.data;
        dq_oe <= is_write;
        ce_n <= 1'b0;
      end else if (busy) begin
        cnt <= cnt + 4'h1;
        if (cnt == 4'h0) begin
          // Write keeps output gate high so the device does not inhibit the write.
          we_n <= !wr;
          oe_n <= wr;
        end else if (wr && cnt == 4'(LOW_CYC)) begin
          we_n <= 1'b1;
        end else if (!wr && cnt == 4'(RD_CYC)) begin
          rd_data <= dq_sync;
          oe_n <= 1'b1;
        end else if (cnt == 4'(RD_CYC + 1)) begin
          ce_n <= 1'b1;
          dq_oe <= 1'b0;
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/pnce_host.sv ====
// Host controller that sequences commands to an asynchronous x16 NOR flash.
// Assumes a single 10 MHz clock; the data pins return through two flip-flops.
`timescale 1ns/1ps
`default_nettype none
`include "pnce_consts.svh"
module pnce_host
  import pnce_pkg::*;
#(
  parameter int unsigned RECOVERY_NS = `PNCE_RECOVERY_NS,
  parameter int unsigned POLL_LIMIT = `PNCE_POLL_LIMIT
)
(
  // Clock and reset.
  input wire logic MCLK,
  input wire logic SYS_RST,
  // User request port.
  input wire logic REQ_VALID,
  input wire pnce_req_t REQ,
  output logic REQ_READY,
  output logic DONE,
  output logic FAIL,
  output logic [15:0] RD_DATA,
  // Flash pins.
  output logic FLASH_CE_N,
  output logic FLASH_OE_N,
  output logic FLASH_WE_N,
  output logic FLASH_RST_N,
  output logic [21:0] FLASH_ADDR,
  output logic [15:0] FLASH_DQ_OUT,
  output logic FLASH_DQ_OE,
  input wire logic [15:0] FLASH_DQ_IN
);
  localparam int unsigned RP_CYC = (`PNCE_RESET_PULSE_NS + `PNCE_CLK_NS - 1) / `PNCE_CLK_NS;
  localparam int unsigned RHR_CYC = (RECOVERY_NS + `PNCE_CLK_NS - 1) / `PNCE_CLK_NS;
  localparam int unsigned SUS_CYC = (`PNCE_SUSPEND_NS + `PNCE_CLK_NS - 1) / `PNCE_CLK_NS;
  localparam int unsigned VAL_CYC = (`PNCE_VALID_NS + `PNCE_CLK_NS - 1) / `PNCE_CLK_NS;

  typedef enum logic [2:0] {
    PNCE_IDLE, PNCE_WRITE, PNCE_READ, PNCE_POLL, PNCE_WAIT, PNCE_RESET, PNCE_FINISH
  } pnce_state_t;

  pnce_state_t state;
  pnce_req_t req;
  pnce_word_t seq [6];
  logic [2:0] seq_len;
  logic [2:0] seq_idx;
  logic [31:0] wait_cnt;
  logic [31:0] poll_cnt;
  logic [15:0] prev_rd;
  logic [1:0] reread;
  logic have_prev;
  logic use_poll;
  logic [15:0] dq_meta;
  logic [15:0] dq_sync;
  logic cyc_start;
  logic cyc_write;
  logic cyc_done;
  logic [15:0] cyc_data;
  pnce_word_t cyc_word;
  logic next_toggle_stopped;
  logic next_poll_ok;

  // Two-stage synchroniser on the data pins.
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      dq_meta <= 16'h0000;
      dq_sync <= 16'h0000;
    end else begin
      dq_meta <= FLASH_DQ_IN;
      dq_sync <= dq_meta;
    end
  end

  pnce_cycle u_cycle (
    .clk(MCLK), .rst(SYS_RST), .start(cyc_start), .is_write(cyc_write), .word(cyc_word),
    .done(cyc_done), .rd_data(cyc_data), .ce_n(FLASH_CE_N), .oe_n(FLASH_OE_N),
    .we_n(FLASH_WE_N), .addr(FLASH_ADDR), .dq_out(FLASH_DQ_OUT), .dq_oe(FLASH_DQ_OE),
    .dq_sync(dq_sync)
  );

  // Completion tests: toggle bit steady across two reads, or the poll bit shows the true value.
  always_comb begin
    next_toggle_stopped = have_prev && (prev_rd[`PNCE_BIT_TOGGLE] == cyc_data[`PNCE_BIT_TOGGLE]);
    next_poll_ok = use_poll ? (cyc_data[`PNCE_BIT_POLL] == req.data[`PNCE_BIT_POLL]) : next_toggle_stopped;
  end

  // Sequence builder: loads the unlock prefix and the final word for each operation but read and hard reset; suspend and resume are one word without a prefix.
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int i = 0; i < 6; i++) begin
        seq[i] <= '0;
      end
      seq_len <= 3'h0;
      use_poll <= 1'b0;
    end else if (state == PNCE_IDLE && REQ_VALID) begin
      seq[0] <= '{`PNCE_ADDR_UNLOCK1, `PNCE_DATA_UNLOCK1};
      seq[1] <= '{`PNCE_ADDR_UNLOCK2, `PNCE_DATA_UNLOCK2};
      seq[3] <= '{`PNCE_ADDR_UNLOCK1, `PNCE_DATA_UNLOCK1};
      seq[4] <= '{`PNCE_ADDR_UNLOCK2, `PNCE_DATA_UNLOCK2};
      // Erased data reads all ones, yet erase polling compares the poll bit against bit 7 of the request data.
      use_poll <= 1'b0;
      seq_len <= 3'h3;
      case (REQ.op)
        PNCE_OP_PROGRAM: begin
          seq[2] <= '{`PNCE_ADDR_UNLOCK1, `PNCE_CMD_PROGRAM};
          seq[3] <= '{REQ.addr, REQ.data};
          seq_len <= 3'h4;
          use_poll <= 1'b1;
        end
        PNCE_OP_SECID_PROGRAM: begin
          // Secure ID programs finish by toggle bits only.
          seq[2] <= '{`PNCE_ADDR_UNLOCK1, `PNCE_CMD_SECID_PROGRAM};
          seq[3] <= '{REQ.addr, REQ.data};
          seq_len <= 3'h4;
        end
        PNCE_OP_SECID_LOCK: begin
          seq[2] <= '{`PNCE_ADDR_UNLOCK1, `PNCE_CMD_SECID_LOCK};
          seq[3] <= '{REQ.addr, 16'h0000};
          seq_len <= 3'h4;
        end
        PNCE_OP_SECTOR_ERASE, PNCE_OP_BLOCK_ERASE, PNCE_OP_CHIP_ERASE: begin
          seq[2] <= '{`PNCE_ADDR_UNLOCK1, `PNCE_CMD_ERASE_SETUP};
          seq_len <= 3'h6;
          use_poll <= 1'b1;
          if (REQ.op == PNCE_OP_CHIP_ERASE) begin
            seq[5] <= '{`PNCE_ADDR_UNLOCK1, `PNCE_CMD_CHIP_ERASE};
          end else if (REQ.op == PNCE_OP_SECTOR_ERASE) begin
            seq[5] <= '{REQ.addr, `PNCE_CMD_SECTOR_ERASE};
          end else begin
            seq[5] <= '{REQ.addr, `PNCE_CMD_BLOCK_ERASE};
          end
        end
        PNCE_OP_SUSPEND: begin
          seq[0] <= '{REQ.addr, `PNCE_CMD_SUSPEND};
          seq_len <= 3'h1;
        end
        PNCE_OP_RESUME: begin
          seq[0] <= '{REQ.addr, `PNCE_CMD_RESUME};
          seq_len <= 3'h1;
        end
        PNCE_OP_CFI_ENTRY: seq[2] <= '{`PNCE_ADDR_UNLOCK1, `PNCE_CMD_CFI_ENTRY};
        PNCE_OP_ID_ENTRY: seq[2] <= '{`PNCE_ADDR_UNLOCK1, `PNCE_CMD_ID_ENTRY};
        PNCE_OP_SECID_ENTRY: seq[2] <= '{`PNCE_ADDR_UNLOCK1, `PNCE_CMD_SECID_ENTRY};
        PNCE_OP_EXIT: seq[2] <= '{`PNCE_ADDR_UNLOCK1, `PNCE_CMD_EXIT};
        default: seq_len <= 3'h0;
      endcase
    end
  end

  // Main sequencer; it takes one request at a time and polls for completion only after sequences of four or more words.
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state <= PNCE_IDLE;
      req <= '0;
      seq_idx <= 3'h0;
      wait_cnt <= 32'h0;
      poll_cnt <= 32'h0;
      prev_rd <= 16'h0000;
      have_prev <= 1'b0;
      reread <= 2'h0;
      cyc_start <= 1'b0;
      cyc_write <= 1'b0;
      cyc_word <= '0;
      REQ_READY <= 1'b1;
      DONE <= 1'b0;
      FAIL <= 1'b0;
      RD_DATA <= 16'h0000;
      FLASH_RST_N <= 1'b1;
    end else begin
      cyc_start <= 1'b0;
      DONE <= 1'b0;
      case (state)
        PNCE_IDLE: begin
          if (REQ_VALID) begin
            req <= REQ;
            REQ_READY <= 1'b0;
            FAIL <= 1'b0;
            seq_idx <= 3'h0;
            have_prev <= 1'b0;
            reread <= 2'h0;
            poll_cnt <= 32'h0;
            if (REQ.op == PNCE_OP_HARD_RESET) begin
              FLASH_RST_N <= 1'b0;
              wait_cnt <= 32'(RP_CYC);
              state <= PNCE_RESET;
            end else if (REQ.op == PNCE_OP_READ) begin
              cyc_word <= '{REQ.addr, 16'h0000};
              cyc_write <= 1'b0;
              cyc_start <= 1'b1;
              state <= PNCE_READ;
            end else begin
              state <= PNCE_WRITE;
            end
          end
        end
        PNCE_WRITE: begin
          if (!cyc_start && !cyc_done && seq_idx == 3'h0 && seq_len == 3'h0) begin
            state <= PNCE_FINISH;
          end else if (cyc_done) begin
            if (seq_idx == seq_len) begin
              if (req.op == PNCE_OP_SUSPEND) begin
                wait_cnt <= 32'(SUS_CYC);
                state <= PNCE_WAIT;
              end else if (seq_len >= 3'h4) begin
                // Status reads go to the target address.
                cyc_word <= '{req.op == PNCE_OP_CHIP_ERASE ? req.addr : req.addr, 16'h0000};
                cyc_write <= 1'b0;
                cyc_start <= 1'b1;
                state <= PNCE_POLL;
              end else begin
                state <= PNCE_FINISH;
              end
            end
          end else if (!cyc_start && seq_idx == 3'h0) begin
            cyc_word <= seq[0];
            cyc_write <= 1'b1;
            cyc_start <= 1'b1;
            seq_idx <= 3'h1;
          end
          if (cyc_done && seq_idx != seq_len) begin
            cyc_word <= seq[seq_idx];
            cyc_write <= 1'b1;
            cyc_start <= 1'b1;
            seq_idx <= seq_idx + 3'h1;
          end
        end
        PNCE_READ: begin
          if (cyc_done) begin
            RD_DATA <= cyc_data;
            state <= PNCE_FINISH;
          end
        end
        PNCE_POLL: begin
          if (cyc_done) begin
            prev_rd <= cyc_data;
            have_prev <= 1'b1;
            poll_cnt <= poll_cnt + 32'h1;
            if (next_poll_ok) begin
              // Confirm with two further reads before calling it complete.
              reread <= reread + 2'h1;
              if (reread == 2'h2) begin
                RD_DATA <= cyc_data;
                wait_cnt <= 32'(VAL_CYC);
                state <= PNCE_WAIT;
              end
            end else begin
              reread <= 2'h0;
            end
            if (poll_cnt == 32'(POLL_LIMIT)) begin
              FAIL <= 1'b1;
              state <= PNCE_FINISH;
            end else if (!(next_poll_ok && reread == 2'h2)) begin
              cyc_start <= 1'b1;
            end
          end
        end
        PNCE_WAIT: begin
          if (wait_cnt <= 32'h1) begin
            state <= PNCE_FINISH;
          end else begin
            wait_cnt <= wait_cnt - 32'h1;
          end
        end
        PNCE_RESET: begin
          if (wait_cnt <= 32'h1) begin
            if (!FLASH_RST_N) begin
              FLASH_RST_N <= 1'b1;
              wait_cnt <= 32'(RHR_CYC);
            end else begin
              state <= PNCE_FINISH;
            end
          end else begin
            wait_cnt <= wait_cnt - 32'h1;
          end
        end
        default: begin
          DONE <= 1'b1;
          REQ_READY <= 1'b1;
          state <= PNCE_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== tb/pnce_host_properties.sv ====
// Concurrent checks on the pins and user port of the flash host controller.
// Assumes binding to pnce_host, whose only clock is MCLK.
`timescale 1ns/1ps
`default_nettype none
module pnce_host_properties
  import pnce_pkg::*;
(
  // Clock and reset.
  input wire logic MCLK,
  input wire logic SYS_RST,
  // User side.
  input wire logic REQ_VALID,
  input wire pnce_req_t REQ,
  input wire logic REQ_READY,
  input wire logic DONE,
  input wire logic FAIL,
  // Flash pins.
  input wire logic FLASH_CE_N,
  input wire logic FLASH_OE_N,
  input wire logic FLASH_WE_N,
  input wire logic FLASH_RST_N,
  input wire logic [21:0] FLASH_ADDR,
  input wire logic [15:0] FLASH_DQ_OUT,
  input wire logic FLASH_DQ_OE
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (SYS_RST);

  // A write strobe is never combined with the gate or a deselected chip.
  a_reset_idle_pins: assert property ($fell(SYS_RST) |-> REQ_READY && FLASH_CE_N && FLASH_WE_N && !DONE)
    else $error("pins not idle after reset");
  a_write_gate_high: assert property (!FLASH_WE_N |-> FLASH_OE_N && !FLASH_CE_N)
    else $error("write strobe with gate low or chip deselected");
  a_no_bus_fight: assert property (!FLASH_OE_N |-> !FLASH_DQ_OE)
    else $error("host drives data during a read");
  // Data must still be driven at the rising strobe, address and data steady meanwhile.
  a_data_at_rise: assert property ($rose(FLASH_WE_N) |-> !FLASH_CE_N && FLASH_DQ_OE)
    else $error("data or chip select gone at strobe rise");
  a_write_word_stable: assert property (!FLASH_WE_N |-> $stable(FLASH_ADDR) && $stable(FLASH_DQ_OUT))
    else $error("address or data moved during write strobe");
  // The hard reset pulse is 500 ns, five cycles.
  a_reset_pulse_min: assert property ($fell(FLASH_RST_N) |-> !FLASH_RST_N [*5])
    else $error("hard reset pulse too short");
  a_idle_released: assert property (REQ_READY |-> FLASH_CE_N && FLASH_WE_N && FLASH_RST_N)
    else $error("flash pins active while idle");
  a_done_one_cycle: assert property (DONE |=> !DONE)
    else $error("done longer than one cycle");
  a_taken_busy: assert property (REQ_VALID && REQ_READY |=> !REQ_READY)
    else $error("request taken but still ready");
  c_chip_erase: cover property (REQ_VALID && REQ_READY && REQ.op == PNCE_OP_CHIP_ERASE);
  c_fail: cover property ($rose(FAIL));
  c_hard_reset: cover property ($fell(FLASH_RST_N));
  c_suspend: cover property (REQ_VALID && REQ_READY && REQ.op == PNCE_OP_SUSPEND);
endmodule
`default_nettype wire

// ==== tb/pnce_flash_model.sv ====
// Behavioural model of the x16 NOR flash on the host's pins.
// Assumes the host drives all strobes; busy times are real delays in ns.
`timescale 1ns/1ps
`default_nettype none
module pnce_flash_model #(
  parameter logic [15:0] MFR_CODE = 16'h00c3, // Arbitrary value.
  parameter logic [15:0] DEV_CODE = 16'h5a5a, // Arbitrary value.
  parameter int PROG_NS = 3000,
  parameter int ERASE_NS = 20000
) (
  // Control pins.
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic rst_n,
  input wire logic wp_n,
  // Address and data.
  input wire logic [21:0] addr,
  input wire logic [15:0] din,
  output logic [15:0] dout
);
  logic [15:0] mem [int];
  logic [21:0] lat_a = 22'h000000;
  logic [15:0] prog_d = 16'h0000;
  logic ers = 1'b0;
  logic tgl = 1'b0;
  realtime done_at = 0;
  realtime fell_at = 0;
  int step = 0;
  int mode = 0;
  // Secure words are kept in the same store with bit 22 set, where no erase reaches them.
  logic susp = 1'b0;
  logic lck = 1'b0;
  logic [21:0] era = 22'h000000;
  realtime rest = 0;

  // Command decoder; the upper data byte is ignored.
  task automatic decode(input logic [21:0] a, input logic [15:0] d);
    logic [7:0] c;
    logic blk;
    c = d[7:0];
    blk = !wp_n && (c == 8'h10 || a < 22'h008000) || susp && a[21:11] == era[21:11];
    // Suspend is the one command an erase still listens to; the time left is kept for the resume.
    if (step == 0 && c == 8'hb0 && ers && $realtime < done_at) begin
      rest = done_at - $realtime;
      done_at = 0;
      susp = 1'b1;
      return;
    end
    if ($realtime < done_at) return;
    if (step == 0 && c == 8'h30 && susp) begin
      done_at = $realtime + rest;
      ers = 1'b1;
      susp = 1'b0;
      return;
    end
    if (step == 0 && c == 8'hf0) mode = 0;
    if ((step == 0 || step == 3) && a[10:0] == 11'h555 && c == 8'haa) step++;
    else if ((step == 1 || step == 4) && a[10:0] == 11'h2aa && c == 8'h55) step++;
    else if (step == 2 && c == 8'h80) step = 3;
    else if (step == 2 && c == 8'ha0) step = 9;
    else if (step == 2 && c == 8'ha5) step = 10;
    else if (step == 2 && c == 8'h85) step = 11;
    else if (step == 2) begin
      mode = c == 8'h90 ? 1 : c == 8'h98 ? 2 : c == 8'h88 ? 3 : 0;
      step = 0;
    end else if (step == 9) begin
      if (!blk) begin
        mem[a] = (mem.exists(a) ? mem[a] : 16'hffff) & d;
        prog_d = d;
        ers = 1'b0;
        done_at = $realtime + PROG_NS;
      end
      step = 0;
    end else if (step == 10) begin
      if (!lck) begin
        mem[{1'b1, a}] = (mem.exists({1'b1, a}) ? mem[{1'b1, a}] : 16'hffff) & d;
        prog_d = d;
        ers = 1'b0;
        done_at = $realtime + PROG_NS;
      end
      step = 0;
    end else if (step == 11) begin
      lck = 1'b1;
      step = 0;
    end else if (step == 5 && !blk && c inside {8'h10, 8'h50, 8'h30}) begin
      era = a;
      foreach (mem[k]) if (!k[22] && (c == 8'h10 || c == 8'h50 && k[21:11] == a[21:11] ||
          c == 8'h30 && k[21:15] == a[21:15]))
        mem[k] = 16'hffff;
      ers = 1'b1;
      done_at = $realtime + ERASE_NS;
      step = 0;
    end else step = 0;
  endtask

  // Address is latched at the falling write strobe, if the chip is already selected.
  always @(negedge we_n) begin
    fell_at = $realtime;
    if (!ce_n) lat_a = addr;
  end
  // Data is taken at the rising strobe; glitches and a low gate start nothing.
  always @(posedge we_n) begin
    if (!ce_n && oe_n && rst_n && $realtime - fell_at >= 5.0) decode(lat_a, din);
  end
  // A hard reset aborts work and returns to read mode.
  always @(negedge rst_n) begin
    done_at = 0;
    susp = 1'b0;
    step = 0;
    mode = 0;
  end
  // Each read start advances the toggle bits.
  always @(negedge oe_n) begin
    if (!ce_n) tgl = ~tgl;
  end
  // A released bus flips rather than holding a stale value the host might trust.
  always @(ce_n, oe_n, addr, tgl, rst_n) begin
    if (ce_n || oe_n) dout = ~dout;
    else if ($realtime < done_at) dout = {8'h00, ers ? 1'b0 : ~prog_d[7], tgl, 3'b000, ers & tgl, 2'b00};
    else if (mode == 1) dout = addr[0] ? DEV_CODE : MFR_CODE;
    else if (susp && addr[21:11] == era[21:11]) dout = {8'h00, 2'b11, 3'b000, tgl, 2'b00};
    else if (mode == 2) dout = addr == 22'h000010 ? 16'h0051 : 16'h0000;
    else if (mode == 3) dout = mem.exists({1'b1, addr}) ? mem[{1'b1, addr}] : 16'hffff;
    else dout = mem.exists(addr) ? mem[addr] : 16'hffff;
  end
endmodule
`default_nettype wire

// ==== tb/pnce_host_test.sv ====
// Self-checking bench for the flash host controller against a flash model.
// Assumes pnce_pkg compiled first; the checker is bound below the module.
`timescale 1ns/1ps
`default_nettype none
module pnce_host_test
  import pnce_pkg::*;
;
  localparam logic [15:0] MFR = 16'h00c3; // Arbitrary value.
  localparam logic [15:0] DEV = 16'h5a5a; // Arbitrary value.
  logic MCLK = 1'b0, SYS_RST = 1'b1, REQ_VALID = 1'b0, wp_n = 1'b1;
  pnce_req_t REQ = '0;
  logic REQ_READY, DONE, FAIL, ce_n, oe_n, we_n, rst_n, dq_oe;
  logic [15:0] RD_DATA, dq_out, dq_in, d;
  logic [21:0] addr, a;
  int seed = 32'h9a07, miscompares = 0, n_compared = 0, cycles = 0;
  pnce_op_t eop [3] = '{PNCE_OP_SECTOR_ERASE, PNCE_OP_BLOCK_ERASE, PNCE_OP_CHIP_ERASE};

  pnce_host #(.RECOVERY_NS(2000), .POLL_LIMIT(64)) u_dut (.MCLK(MCLK), .SYS_RST(SYS_RST), .REQ_VALID(REQ_VALID),
    .REQ(REQ), .REQ_READY(REQ_READY), .DONE(DONE), .FAIL(FAIL), .RD_DATA(RD_DATA), .FLASH_CE_N(ce_n),
    .FLASH_OE_N(oe_n), .FLASH_WE_N(we_n), .FLASH_RST_N(rst_n), .FLASH_ADDR(addr), .FLASH_DQ_OUT(dq_out),
    .FLASH_DQ_OE(dq_oe), .FLASH_DQ_IN(dq_in));
  pnce_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_flash (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .rst_n(rst_n), .wp_n(wp_n), .addr(addr), .din(dq_out), .dout(dq_in));

  task automatic give_verdict();
    if (miscompares == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      miscompares++;
    end
  endtask
  // Programming can only clear bits, so the word left is the old one masked by the new.
  function automatic logic [15:0] prog_result(input logic [15:0] old, input logic [15:0] nw);
    return old & nw;
  endfunction
  // One request: held until taken, then a bounded wait for its done pulse.
  task automatic do_req(input pnce_op_t op, input logic [21:0] ra, input logic [15:0] rd);
    int n;
    @(posedge MCLK);
    #1;
    REQ_VALID = 1'b1;
    REQ = '{op: op, addr: ra, data: rd};
    while (REQ_READY !== 1'b1) begin
      @(posedge MCLK);
      #1;
    end
    @(posedge MCLK);
    #1;
    REQ_VALID = 1'b0;
    n = 0;
    while (DONE !== 1'b1 && n < 5000) begin
      @(posedge MCLK);
      #1;
      n++;
    end
    check("done", {15'h0000, DONE}, 16'h0001);
  endtask
  task automatic rd_chk(input string what, input logic [21:0] ra, input logic [15:0] exp);
    do_req(PNCE_OP_READ, ra, 16'h0000);
    check(what, RD_DATA, exp);
  endtask

  initial begin
    forever #50 MCLK = ~MCLK;
  end
  // A hang counts against the run and closes it.
  always @(posedge MCLK) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    repeat (10) @(posedge MCLK);
    #1 SYS_RST = 1'b0;
    // Random words above the boot block, each read back.
    repeat (4) begin
      a = 22'($random(seed));
      a[21] = 1'b1;
      d = 16'($random(seed));
      do_req(PNCE_OP_PROGRAM, a, d);
      check("fail", {15'h0000, FAIL}, 16'h0000);
      rd_chk("program", a, prog_result(16'hffff, d));
    end
    // Each erase kind clears a freshly zeroed word.
    for (int i = 0; i < 3; i++) begin
      do_req(PNCE_OP_PROGRAM, a, 16'h0000);
      rd_chk("zeroed", a, 16'h0000);
      do_req(eop[i], a, 16'hffff);
      rd_chk("erase", a, 16'hffff);
    end
    // The protected boot block ignores the program, so polling gives up.
    wp_n = 1'b0;
    do_req(PNCE_OP_PROGRAM, 22'h000100, 16'h1234);
    check("boot fail", {15'h0000, FAIL}, 16'h0001);
    rd_chk("boot word", 22'h000100, 16'hffff);
    wp_n = 1'b1;
    // Identification and query modes, then back to the array.
    do_req(PNCE_OP_ID_ENTRY, 22'h000000, 16'h0000);
    rd_chk("maker", 22'h000000, MFR);
    rd_chk("device", 22'h000001, DEV);
    do_req(PNCE_OP_EXIT, 22'h000000, 16'h0000);
    do_req(PNCE_OP_CFI_ENTRY, 22'h000000, 16'h0000);
    rd_chk("query", 22'h000010, 16'h0051);
    do_req(PNCE_OP_EXIT, 22'h000000, 16'h0000);
    rd_chk("array", 22'h000010, 16'hffff);
    // Secure space: toggle-bit completion, then a lock-out that freezes the word.
    do_req(PNCE_OP_SECID_ENTRY, 22'h000000, 16'h0000);
    do_req(PNCE_OP_SECID_PROGRAM, 22'h000011, 16'h1234);
    check("secure fail", {15'h0000, FAIL}, 16'h0000);
    rd_chk("secure word", 22'h000011, 16'h1234);
    do_req(PNCE_OP_SECID_LOCK, 22'h000011, 16'h0000);
    do_req(PNCE_OP_SECID_PROGRAM, 22'h000011, 16'h0000);
    rd_chk("locked word", 22'h000011, 16'h1234);
    do_req(PNCE_OP_EXIT, 22'h000000, 16'h0000);
    // A zero poll target ends the erase request early, so the erase can be suspended while it runs.
    do_req(PNCE_OP_PROGRAM, a, 16'h0000);
    do_req(PNCE_OP_SECTOR_ERASE, a, 16'h0000);
    do_req(PNCE_OP_SUSPEND, a, 16'h0000);
    do_req(PNCE_OP_READ, a, 16'h0000);
    d = RD_DATA;
    do_req(PNCE_OP_READ, a, 16'h0000);
    check("suspended sector", {13'h0000, d[7:6], d[2] ^ RD_DATA[2]}, 16'h0007);
    do_req(PNCE_OP_PROGRAM, a ^ 22'h000800, 16'h1234);
    rd_chk("other sector", a ^ 22'h000800, prog_result(16'hffff, 16'h1234));
    do_req(PNCE_OP_PROGRAM, a, 16'h0000);
    check("suspended program", {15'h0000, FAIL}, 16'h0001);
    do_req(PNCE_OP_RESUME, a, 16'h0000);
    do_req(PNCE_OP_READ, a, 16'h0000);
    check("resumed busy", {15'h0000, RD_DATA[7]}, 16'h0000);
    repeat (200) @(posedge MCLK);
    rd_chk("resumed", a, 16'hffff);
    // Suspend and resume with nothing running, then a hard reset.
    do_req(PNCE_OP_SUSPEND, a, 16'h0000);
    do_req(PNCE_OP_RESUME, a, 16'h0000);
    do_req(PNCE_OP_PROGRAM, a, 16'h00aa);
    do_req(PNCE_OP_HARD_RESET, 22'h000000, 16'h0000);
    rd_chk("after reset", a, 16'h00aa);
    // A second reset in mid-run.
    @(posedge MCLK);
    #1 SYS_RST = 1'b1;
    @(posedge MCLK);
    #1 SYS_RST = 1'b0;
    check("ready", {15'h0000, REQ_READY}, 16'h0001);
    rd_chk("array again", a, 16'h00aa);
    give_verdict();
  end
endmodule
bind pnce_host pnce_host_properties u_props (.MCLK(MCLK), .SYS_RST(SYS_RST), .REQ_VALID(REQ_VALID), .REQ(REQ),
  .REQ_READY(REQ_READY), .DONE(DONE), .FAIL(FAIL), .FLASH_CE_N(FLASH_CE_N), .FLASH_OE_N(FLASH_OE_N),
  .FLASH_WE_N(FLASH_WE_N), .FLASH_RST_N(FLASH_RST_N), .FLASH_ADDR(FLASH_ADDR), .FLASH_DQ_OUT(FLASH_DQ_OUT),
  .FLASH_DQ_OE(FLASH_DQ_OE));
`default_nettype wire
